// ### pkg/abx_consts.vh
// Constants for the integer execute block: operation codes, status bit
// positions, software register offsets, cycle counts and reset values.
// Assumes it is included by bare name from the design files.
`ifndef ABX_CONSTS_VH
`define ABX_CONSTS_VH

// Operation codes presented on op_code_in
`define ABX_OP_SUM 6'h00
`define ABX_OP_SUM_CARRY 6'h01
`define ABX_OP_PAIR_PLUS 6'h02
`define ABX_OP_DIFF_REGS 6'h03
`define ABX_OP_DIFF_IMM 6'h04
`define ABX_OP_DIFF_RB 6'h05
`define ABX_OP_DIFF_IB 6'h06
`define ABX_OP_PAIR_MINUS 6'h07
`define ABX_OP_CONJ_REGS 6'h08
`define ABX_OP_CONJ_IMM 6'h09
`define ABX_OP_DISJ_REGS 6'h0A
`define ABX_OP_DISJ_IMM 6'h0B
`define ABX_OP_XOR_REGS 6'h0C
`define ABX_OP_ONES_INV 6'h0D
`define ABX_OP_TWOS_INV 6'h0E
`define ABX_OP_SET_MASK 6'h0F
`define ABX_OP_CLR_MASK 6'h10
`define ABX_OP_PLUS_ONE 6'h11
`define ABX_OP_MINUS_ONE 6'h12
`define ABX_OP_ZS_CHECK 6'h13
`define ABX_OP_ZERO_REG 6'h14
`define ABX_OP_ONES_REG 6'h15
`define ABX_OP_PROD_U 6'h16
`define ABX_OP_PROD_S 6'h17
`define ABX_OP_PROD_M 6'h18
`define ABX_OP_FPROD_U 6'h19
`define ABX_OP_FPROD_S 6'h1A
`define ABX_OP_FPROD_M 6'h1B
`define ABX_OP_REL_GOTO 6'h1C
`define ABX_OP_PTR_GOTO 6'h1D
`define ABX_OP_REL_ENTER 6'h1E
`define ABX_OP_PTR_ENTER 6'h1F
`define ABX_OP_SUB_EXIT 6'h20
`define ABX_OP_IRQ_EXIT 6'h21
`define ABX_OP_EQ_SKIP 6'h22

// Status register bit positions
`define ABX_F_C 0
`define ABX_F_Z 1
`define ABX_F_N 2
`define ABX_F_V 3
`define ABX_F_S 4
`define ABX_F_H 5
`define ABX_F_I 7

// Software register offsets
`define ABX_REG_STATUS 3'h0
`define ABX_REG_PC_LO 3'h1
`define ABX_REG_PC_HI 3'h2
`define ABX_REG_DEPTH 3'h3
`define ABX_REG_RES_LO 3'h4
`define ABX_REG_RES_HI 3'h5

// Cycle counts per instruction class
`define ABX_CYC_ONE 3'd1
`define ABX_CYC_TWO 3'd2
`define ABX_CYC_THREE 3'd3
`define ABX_CYC_FOUR 3'd4

// Reset values and stack depth
`define ABX_RST_STATUS 8'h00
`define ABX_RST_PC 16'h0000
`define ABX_STK_DEPTH 16

`endif

// ### verilog/abx_mul.v
// Two-cycle multiplier: samples the operands when told and holds the
// sixteen-bit product, plain or fractional, from the next edge on.
// Assumes the caller asserts load only on the cycle it accepts a product op.
`timescale 1ns/10ps
module abx_mul (
   input wire clock_in,
   input wire nrst_in,
   input wire ce_in,
   input wire load_in,
   input wire [7:0] a_in,
   input wire [7:0] b_in,
   input wire a_signed_in,
   input wire b_signed_in,
   input wire frac_in,
   output reg [15:0] prod_out,
   output reg carry_out
);
   wire signed [8:0] a_ext;
   wire signed [8:0] b_ext;
   wire signed [17:0] full;
   wire [15:0] raw;

   // Sign extension picks signed or unsigned reading per operand
   assign a_ext = {a_signed_in & a_in[7], a_in};
   assign b_ext = {b_signed_in & b_in[7], b_in};
   assign full = a_ext * b_ext;
   assign raw = full[15:0];

   // Carry is taken from bit 15 before the fractional shift
   always @(posedge clock_in) begin
      if (!nrst_in) begin
         prod_out <= 16'h0000;
         carry_out <= 1'b0;
      end else if (ce_in && load_in) begin
         prod_out <= frac_in ? {raw[14:0], 1'b0} : raw;
         carry_out <= raw[15];
      end
   end
endmodule // abx_mul

// ### verilog/abx_core.v
// Integer execute block: arithmetic, logic, multiply and program flow,
// with status flags, program counter and a return-address stack.
// Assumes the decoder holds operands steady only in the accept cycle.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "abx_consts.vh"

// How it works
// - Register add, optional carry, flags ZCNVH
// - Register subtract, optional borrow, flags ZCNVH
// - Constant subtract, optional borrow, flags ZCNVH
// - Pair plus constant, two cycles, ZCNVS
// - Pair minus constant, two cycles, ZCNVS
// - AND register or constant, flags ZNV
// - OR, XOR, set-mask in one cycle, ZNV
// - Ones inversion ZCNV, negation adds H
// - Clear-mask ANDs with inverted constant, ZNV
// - Increment, decrement, test update ZNV
// - Zero via XOR with flags; ones, none
// - Products into R1:R0, two cycles, ZC
// - Fractional products shifted left one, ZC
// - Relative and pointer goto, two cycles
// - Relative and pointer call, three cycles
// - Equal-skip jumps next instruction, 1/2/3 cycles
module abx_core (
   input wire clock_in,
   input wire nrst_in,
   input wire ce_in,
   input wire op_valid_in,
   input wire [5:0] op_code_in,
   input wire [7:0] rd_val_in,
   input wire [7:0] rr_val_in,
   input wire [7:0] imm_in,
   input wire [15:0] pair_in,
   input wire [11:0] offset_in,
   input wire [15:0] z_ptr_in,
   input wire next_two_word_in,
   input wire [2:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output wire ready_out,
   output reg done_out,
   output reg [7:0] res_lo_out,
   output reg [7:0] res_hi_out,
   output reg wr_lo_out,
   output reg wr_hi_out,
   output reg [7:0] status_out,
   output reg [15:0] pc_out,
   output reg [7:0] reg_rdata_out
);
   localparam ST_IDLE = 2'b01;
   localparam ST_WAIT = 2'b10;

   reg [1:0] st_r;
   reg [1:0] cnt_r;
   reg [5:0] op_r;
   reg [7:0] rd_r;
   reg [7:0] rr_r;
   reg [7:0] imm_r;
   reg [15:0] pair_r;
   reg [11:0] off_r;
   reg [15:0] z_r;
   reg two_r;
   reg [15:0] stk [0:`ABX_STK_DEPTH-1];
   reg [3:0] sp_r;

   wire idle;
   wire accept;
   wire [5:0] op;
   wire [7:0] rd;
   wire [7:0] rr;
   wire [7:0] imm;
   wire [15:0] pair;
   wire [11:0] off;
   wire [15:0] zp;
   wire two_word;
   reg [2:0] cycles;
   wire commit;
   wire is_mul;
   wire [15:0] prod;
   wire prod_c;

   assign idle = (st_r == ST_IDLE);
   assign ready_out = idle;
   assign accept = ce_in & idle & op_valid_in;

   // Idle uses the live operands, a multi-cycle op its latched copy
   assign op = idle ? op_code_in : op_r;
   assign rd = idle ? rd_val_in : rd_r;
   assign rr = idle ? rr_val_in : rr_r;
   assign imm = idle ? imm_in : imm_r;
   assign pair = idle ? pair_in : pair_r;
   assign off = idle ? offset_in : off_r;
   assign zp = idle ? z_ptr_in : z_r;
   assign two_word = idle ? next_two_word_in : two_r;
   assign is_mul = (op >= `ABX_OP_PROD_U) && (op <= `ABX_OP_FPROD_M);

   // Cycle count of the operation being accepted
   always @* begin
      case (op)
         `ABX_OP_PAIR_PLUS, `ABX_OP_PAIR_MINUS: cycles = `ABX_CYC_TWO;
         `ABX_OP_PROD_U, `ABX_OP_PROD_S, `ABX_OP_PROD_M,
         `ABX_OP_FPROD_U, `ABX_OP_FPROD_S, `ABX_OP_FPROD_M:
            cycles = `ABX_CYC_TWO;
         `ABX_OP_REL_GOTO, `ABX_OP_PTR_GOTO: cycles = `ABX_CYC_TWO;
         `ABX_OP_REL_ENTER, `ABX_OP_PTR_ENTER: cycles = `ABX_CYC_THREE;
         `ABX_OP_SUB_EXIT, `ABX_OP_IRQ_EXIT: cycles = `ABX_CYC_FOUR;
         `ABX_OP_EQ_SKIP: begin
            if (rd != rr)
               cycles = `ABX_CYC_ONE;
            else if (two_word)
               cycles = `ABX_CYC_THREE;
            else
               cycles = `ABX_CYC_TWO;
         end
         default: cycles = `ABX_CYC_ONE;
      endcase
   end

   // Results land on the accept edge for one-cycle ops, else on the last
   assign commit = ce_in & ((accept & (cycles == 3'd1)) | (~idle & (cnt_r == 2'd1)));

   // Multiplier samples on accept; its product is ready for the second edge
   abx_mul u_mul (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .ce_in(ce_in),
      .load_in(accept & is_mul),
      .a_in(rd),
      .b_in(rr),
      .a_signed_in(op == `ABX_OP_PROD_S || op == `ABX_OP_PROD_M ||
                   op == `ABX_OP_FPROD_S || op == `ABX_OP_FPROD_M),
      .b_signed_in(op == `ABX_OP_PROD_S || op == `ABX_OP_FPROD_S),
      .frac_in(op >= `ABX_OP_FPROD_U),
      .prod_out(prod),
      .carry_out(prod_c)
   );

   // Shared eight-bit adder and subtractor
   wire use_imm;
   wire [7:0] a_sel;
   wire [7:0] b_sel;
   wire cin;
   wire bin;
   wire [8:0] sum9;
   wire [4:0] sum_h;
   wire [8:0] dif9;
   wire [4:0] dif_h;
   wire [16:0] wsum;
   wire [16:0] wdif;

   assign use_imm = (op == `ABX_OP_DIFF_IMM) || (op == `ABX_OP_DIFF_IB);
   assign a_sel = (op == `ABX_OP_TWOS_INV) ? 8'h00 : rd;
   assign b_sel = (op == `ABX_OP_TWOS_INV) ? rd :
                  ((op == `ABX_OP_PLUS_ONE) || (op == `ABX_OP_MINUS_ONE)) ? 8'h01 :
                  use_imm ? imm : rr;
   assign cin = (op == `ABX_OP_SUM_CARRY) & status_out[`ABX_F_C];
   assign bin = ((op == `ABX_OP_DIFF_RB) || (op == `ABX_OP_DIFF_IB)) &
                status_out[`ABX_F_C];
   assign sum9 = {1'b0, a_sel} + {1'b0, b_sel} + {8'h00, cin};
   assign sum_h = {1'b0, a_sel[3:0]} + {1'b0, b_sel[3:0]} + {4'h0, cin};
   assign dif9 = {1'b0, a_sel} - {1'b0, b_sel} - {8'h00, bin};
   assign dif_h = {1'b0, a_sel[3:0]} - {1'b0, b_sel[3:0]} - {4'h0, bin};
   // Word ops take a six-bit constant, as the pair forms encode it
   assign wsum = {1'b0, pair} + {11'h000, imm[5:0]};
   assign wdif = {1'b0, pair} - {11'h000, imm[5:0]};

   reg [7:0] lo_nxt;
   reg [7:0] hi_nxt;
   reg wlo_nxt;
   reg whi_nxt;
   reg [7:0] f_nxt;
   reg [15:0] pc_nxt;
   reg push;
   reg pop;
   reg [15:0] pc_rel;

   // Flag helpers: zero, sign and overflow per result class
   always @* begin
      lo_nxt = rd;
      hi_nxt = 8'h00;
      wlo_nxt = 1'b1;
      whi_nxt = 1'b0;
      f_nxt = status_out;
      pc_rel = pc_out + {{4{off[11]}}, off} + 16'h0001;
      pc_nxt = pc_out + 16'h0001;
      push = 1'b0;
      pop = 1'b0;
      case (op)
         `ABX_OP_SUM, `ABX_OP_SUM_CARRY: begin
            lo_nxt = sum9[7:0];
            f_nxt[`ABX_F_C] = sum9[8];
            f_nxt[`ABX_F_H] = sum_h[4];
            f_nxt[`ABX_F_V] = (a_sel[7] & b_sel[7] & ~sum9[7]) |
                              (~a_sel[7] & ~b_sel[7] & sum9[7]);
         end
         `ABX_OP_DIFF_REGS, `ABX_OP_DIFF_IMM, `ABX_OP_DIFF_RB, `ABX_OP_DIFF_IB,
         `ABX_OP_TWOS_INV: begin
            lo_nxt = dif9[7:0];
            f_nxt[`ABX_F_C] = dif9[8];
            f_nxt[`ABX_F_H] = dif_h[4];
            f_nxt[`ABX_F_V] = (a_sel[7] & ~b_sel[7] & ~dif9[7]) |
                              (~a_sel[7] & b_sel[7] & dif9[7]);
         end
         `ABX_OP_PAIR_PLUS: begin
            {hi_nxt, lo_nxt} = wsum[15:0];
            whi_nxt = 1'b1;
            f_nxt[`ABX_F_C] = ~wsum[15] & pair[15];
            f_nxt[`ABX_F_V] = ~pair[15] & wsum[15];
         end
         `ABX_OP_PAIR_MINUS: begin
            {hi_nxt, lo_nxt} = wdif[15:0];
            whi_nxt = 1'b1;
            f_nxt[`ABX_F_C] = wdif[15] & ~pair[15];
            f_nxt[`ABX_F_V] = pair[15] & ~wdif[15];
         end
         `ABX_OP_CONJ_REGS, `ABX_OP_ZS_CHECK: lo_nxt = rd & rr;
         `ABX_OP_CONJ_IMM: lo_nxt = rd & imm;
         `ABX_OP_DISJ_REGS: lo_nxt = rd | rr;
         `ABX_OP_DISJ_IMM, `ABX_OP_SET_MASK: lo_nxt = rd | imm;
         `ABX_OP_XOR_REGS, `ABX_OP_ZERO_REG: lo_nxt = rd ^ rr;
         `ABX_OP_CLR_MASK: lo_nxt = rd & (8'hFF - imm);
         `ABX_OP_ONES_INV: begin
            lo_nxt = 8'hFF - rd;
            f_nxt[`ABX_F_C] = 1'b1;
         end
         `ABX_OP_PLUS_ONE: begin
            lo_nxt = sum9[7:0];
            f_nxt[`ABX_F_V] = (sum9[7:0] == 8'h80);
         end
         `ABX_OP_MINUS_ONE: begin
            lo_nxt = dif9[7:0];
            f_nxt[`ABX_F_V] = (dif9[7:0] == 8'h7F);
         end
         `ABX_OP_ONES_REG: lo_nxt = 8'hFF;
         `ABX_OP_PROD_U, `ABX_OP_PROD_S, `ABX_OP_PROD_M,
         `ABX_OP_FPROD_U, `ABX_OP_FPROD_S, `ABX_OP_FPROD_M: begin
            {hi_nxt, lo_nxt} = prod;
            whi_nxt = 1'b1;
            f_nxt[`ABX_F_C] = prod_c;
            f_nxt[`ABX_F_Z] = (prod == 16'h0000);
         end
         `ABX_OP_REL_GOTO: begin
            wlo_nxt = 1'b0;
            pc_nxt = pc_rel;
         end
         `ABX_OP_PTR_GOTO: begin
            wlo_nxt = 1'b0;
            pc_nxt = zp;
         end
         `ABX_OP_REL_ENTER: begin
            wlo_nxt = 1'b0;
            push = 1'b1;
            pc_nxt = pc_rel;
         end
         `ABX_OP_PTR_ENTER: begin
            wlo_nxt = 1'b0;
            push = 1'b1;
            pc_nxt = zp;
         end
         `ABX_OP_SUB_EXIT, `ABX_OP_IRQ_EXIT: begin
            wlo_nxt = 1'b0;
            pop = 1'b1;
            pc_nxt = stk[sp_r - 4'd1];
            if (op == `ABX_OP_IRQ_EXIT)
               f_nxt[`ABX_F_I] = 1'b1;
         end
         `ABX_OP_EQ_SKIP: begin
            wlo_nxt = 1'b0;
            if (rd == rr)
               pc_nxt = pc_out + (two_word ? 16'h0003 : 16'h0002);
         end
         default: wlo_nxt = 1'b0;
      endcase

      // Zero and sign follow the byte result for every flag-setting byte op
      case (op)
         `ABX_OP_SUM, `ABX_OP_SUM_CARRY, `ABX_OP_DIFF_REGS, `ABX_OP_DIFF_IMM,
         `ABX_OP_DIFF_RB, `ABX_OP_DIFF_IB, `ABX_OP_TWOS_INV, `ABX_OP_ONES_INV,
         `ABX_OP_PLUS_ONE, `ABX_OP_MINUS_ONE: begin
            f_nxt[`ABX_F_Z] = (lo_nxt == 8'h00);
            f_nxt[`ABX_F_N] = lo_nxt[7];
            if (op == `ABX_OP_ONES_INV)
               f_nxt[`ABX_F_V] = 1'b0;
         end
         `ABX_OP_CONJ_REGS, `ABX_OP_CONJ_IMM, `ABX_OP_DISJ_REGS, `ABX_OP_DISJ_IMM,
         `ABX_OP_XOR_REGS, `ABX_OP_SET_MASK, `ABX_OP_CLR_MASK, `ABX_OP_ZS_CHECK,
         `ABX_OP_ZERO_REG: begin
            f_nxt[`ABX_F_Z] = (lo_nxt == 8'h00);
            f_nxt[`ABX_F_N] = lo_nxt[7];
            f_nxt[`ABX_F_V] = 1'b0;
         end
         `ABX_OP_PAIR_PLUS, `ABX_OP_PAIR_MINUS: begin
            f_nxt[`ABX_F_Z] = ({hi_nxt, lo_nxt} == 16'h0000);
            f_nxt[`ABX_F_N] = hi_nxt[7];
            f_nxt[`ABX_F_S] = hi_nxt[7] ^ f_nxt[`ABX_F_V];
         end
         default: ;
      endcase
   end

   // Sequencer: latches operands of multi-cycle ops and counts down
   always @(posedge clock_in) begin
      if (!nrst_in) begin
         st_r <= ST_IDLE;
         cnt_r <= 2'd0;
         op_r <= `ABX_OP_SUM;
         rd_r <= 8'h00;
         rr_r <= 8'h00;
         imm_r <= 8'h00;
         pair_r <= 16'h0000;
         off_r <= 12'h000;
         z_r <= 16'h0000;
         two_r <= 1'b0;
      end else if (ce_in) begin
         case (st_r)
            ST_IDLE: begin
               if (accept && cycles != 3'd1) begin
                  st_r <= ST_WAIT;
                  cnt_r <= cycles[1:0] - 2'd1; // Four fits as three remaining
                  op_r <= op_code_in;
                  rd_r <= rd_val_in;
                  rr_r <= rr_val_in;
                  imm_r <= imm_in;
                  pair_r <= pair_in;
                  off_r <= offset_in;
                  z_r <= z_ptr_in;
                  two_r <= next_two_word_in;
               end
            end
            ST_WAIT: begin
               cnt_r <= cnt_r - 2'd1;
               if (cnt_r == 2'd1)
                  st_r <= ST_IDLE;
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // Commit stage; an op's status update wins over a software write
   always @(posedge clock_in) begin
      if (!nrst_in) begin
         done_out <= 1'b0;
         wr_lo_out <= 1'b0;
         wr_hi_out <= 1'b0;
         res_lo_out <= 8'h00;
         res_hi_out <= 8'h00;
         status_out <= `ABX_RST_STATUS;
         pc_out <= `ABX_RST_PC;
         sp_r <= 4'h0;
      end else if (ce_in) begin
         done_out <= commit;
         wr_lo_out <= commit & wlo_nxt;
         wr_hi_out <= commit & whi_nxt;
         if (commit) begin
            res_lo_out <= lo_nxt;
            res_hi_out <= hi_nxt;
            status_out <= f_nxt;
            pc_out <= pc_nxt;
            if (push)
               sp_r <= sp_r + 4'd1;
            if (pop)
               sp_r <= sp_r - 4'd1;
         end else if (reg_wr_in) begin
            if (reg_addr_in == `ABX_REG_STATUS)
               status_out <= reg_wdata_in;
            if (reg_addr_in == `ABX_REG_PC_LO)
               pc_out <= {pc_out[15:8], reg_wdata_in};
            if (reg_addr_in == `ABX_REG_PC_HI)
               pc_out <= {reg_wdata_in, pc_out[7:0]};
         end
      end
   end

   // Return address is pushed in the same edge the branch is taken
   always @(posedge clock_in) begin
      if (ce_in && commit && push)
         stk[sp_r] <= pc_out + 16'h0001;
   end

   // Register read port: data appear the cycle after the strobe
   always @(posedge clock_in) begin
      if (!nrst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (ce_in) begin
         if (reg_rd_in) begin
            case (reg_addr_in)
               `ABX_REG_STATUS: reg_rdata_out <= status_out;
               `ABX_REG_PC_LO: reg_rdata_out <= pc_out[7:0];
               `ABX_REG_PC_HI: reg_rdata_out <= pc_out[15:8];
               `ABX_REG_DEPTH: reg_rdata_out <= {4'h0, sp_r};
               `ABX_REG_RES_LO: reg_rdata_out <= res_lo_out;
               `ABX_REG_RES_HI: reg_rdata_out <= res_hi_out;
               default: reg_rdata_out <= 8'h00;
            endcase
         end else begin
            reg_rdata_out <= 8'h00;
         end
      end
   end
endmodule // abx_core

// ### verification/abx_core_checker.sv
// Checker for the execute block: latency, result and flag relations
// tied to the operands held at accept. Sees only the core's ports.
`timescale 1ns/10ps
`include "abx_consts.vh"
module abx_core_checker (
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire logic op_valid_in,
   input wire logic [5:0] op_code_in,
   input wire logic [7:0] rd_val_in,
   input wire logic [7:0] rr_val_in,
   input wire logic [7:0] imm_in,
   input wire logic [15:0] pair_in,
   input wire logic [11:0] offset_in,
   input wire logic [15:0] z_ptr_in,
   input wire logic next_two_word_in,
   input wire logic ready_out,
   input wire logic done_out,
   input wire logic [7:0] res_lo_out,
   input wire logic [7:0] res_hi_out,
   input wire logic wr_lo_out,
   input wire logic wr_hi_out,
   input wire logic [7:0] status_out,
   input wire logic [15:0] pc_out
);
   logic acc;
   logic [7:0] a_q, b_q, k_q;
   logic [15:0] p_q, z_q, pc_q;
   logic [11:0] o_q;
   logic [1:0] sk_q;
   // Operands are only valid in the accept cycle, so keep a copy
   assign acc = ce_in && ready_out && op_valid_in;
   always @(posedge clock_in) begin
      if (acc) begin
         {a_q, b_q, k_q} <= {rd_val_in, rr_val_in, imm_in};
         {p_q, z_q, o_q} <= {pair_in, z_ptr_in, offset_in};
         pc_q <= pc_out;
         sk_q <= (rd_val_in != rr_val_in) ? 2'h1 : (next_two_word_in ? 2'h3 : 2'h2);
      end
   end
   // A frozen clock enable stretches counts, so it disables checks
   default clocking @(posedge clock_in); endclocking
   default disable iff (!nrst_in || !ce_in);
   chk_add_one: assert property (
      acc && op_code_in == `ABX_OP_SUM |=> done_out && wr_lo_out && res_lo_out == a_q + b_q)
      else $error("byte add wrong");
   chk_pair_two: assert property (
      acc && op_code_in == `ABX_OP_PAIR_PLUS |=> !ready_out ##1 done_out && wr_hi_out
      && {res_hi_out, res_lo_out} == p_q + {10'h000, k_q[5:0]})
      else $error("pair add wrong");
   chk_prod_two: assert property (
      acc && op_code_in == `ABX_OP_PROD_U |=> !ready_out ##1 done_out && wr_hi_out
      && {res_hi_out, res_lo_out} == a_q * b_q)
      else $error("product wrong");
   chk_ret_four: assert property (
      acc && (op_code_in == `ABX_OP_SUB_EXIT || op_code_in == `ABX_OP_IRQ_EXIT)
      |=> !ready_out [*3] ##1 done_out)
      else $error("return wrong");
   chk_irq_sets_i: assert property (
      acc && op_code_in == `ABX_OP_IRQ_EXIT |-> ##4 status_out[`ABX_F_I])
      else $error("irq exit left I clear");
   chk_call_three: assert property (
      acc && op_code_in == `ABX_OP_REL_ENTER |=> !ready_out [*2] ##1 done_out
      && pc_out == pc_q + {{4{o_q[11]}}, o_q} + 16'h0001)
      else $error("relative call wrong");
   chk_goto_ptr: assert property (
      acc && op_code_in == `ABX_OP_PTR_GOTO |=> !ready_out ##1 done_out && pc_out == z_q
      && status_out == $past(status_out, 2))
      else $error("pointer goto wrong");
   chk_skip_pc: assert property (
      acc && op_code_in == `ABX_OP_EQ_SKIP |-> ##[1:3] done_out && pc_out == pc_q + sk_q)
      else $error("equal skip wrong");
   chk_ones_keep: assert property (
      acc && op_code_in == `ABX_OP_ONES_REG |=> res_lo_out == 8'hFF
      && status_out == $past(status_out))
      else $error("all ones op wrong");
   cov_product: cover property (acc && op_code_in == `ABX_OP_PROD_U);
   cov_long_skip: cover property (acc && op_code_in == `ABX_OP_EQ_SKIP && next_two_word_in);
   cov_irq_exit: cover property (acc && op_code_in == `ABX_OP_IRQ_EXIT);
endmodule // abx_core_checker

bind abx_core abx_core_checker abx_core_checker_i (.clock_in, .nrst_in, .ce_in, .op_valid_in,
   .op_code_in, .rd_val_in, .rr_val_in, .imm_in, .pair_in, .offset_in, .z_ptr_in,
   .next_two_word_in, .ready_out, .done_out, .res_lo_out, .res_hi_out, .wr_lo_out,
   .wr_hi_out, .status_out, .pc_out);

// ### verification/abx_regfile_model.sv
// Register file side of the execute block: keeps result bytes.
// Assumes results stand beside their one-cycle write pulses.
`timescale 1ns/10ps
module abx_regfile_model (
   input wire logic clock_in,
   input wire logic wr_lo_in,
   input wire logic wr_hi_in,
   input wire logic [7:0] lo_in,
   input wire logic [7:0] hi_in,
   output logic [7:0] lo_out,
   output logic [7:0] hi_out
);
   // Marker value so a missing first write cannot pass
   initial begin
      lo_out = 8'hA5;
      hi_out = 8'hA5;
   end
   // Capture only on the write pulses
   always @(posedge clock_in) begin
      if (wr_lo_in) lo_out <= lo_in;
      if (wr_hi_in) hi_out <= hi_in;
   end
endmodule // abx_regfile_model

// ### verification/abx_core_tb.sv
// Self-checking bench for the execute block: ops through the request
// port, registers through the software port. Needs the checker bound.
`timescale 1ns/10ps
`include "abx_consts.vh"
`define ABX_CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); \
      end \
   end
module abx_core_tb;
   logic clock_in, nrst_in, ce_in, op_valid_in, next_two_word_in, reg_wr_in, reg_rd_in;
   logic [5:0] op_code_in;
   logic [7:0] rd_val_in, rr_val_in, imm_in, reg_wdata_in;
   logic [15:0] pair_in, z_ptr_in;
   logic [11:0] offset_in;
   logic [2:0] reg_addr_in;
   wire ready_out, done_out, wr_lo_out, wr_hi_out;
   wire [7:0] res_lo_out, res_hi_out, status_out, reg_rdata_out, rf_lo, rf_hi;
   wire [15:0] pc_out;
   int miscompares, num_checks;
   abx_core abx_core_i (.clock_in, .nrst_in, .ce_in, .op_valid_in, .op_code_in, .rd_val_in,
      .rr_val_in, .imm_in, .pair_in, .offset_in, .z_ptr_in, .next_two_word_in, .reg_addr_in,
      .reg_wdata_in, .reg_wr_in, .reg_rd_in, .ready_out, .done_out, .res_lo_out, .res_hi_out,
      .wr_lo_out, .wr_hi_out, .status_out, .pc_out, .reg_rdata_out);
   abx_regfile_model abx_regfile_model_i (.clock_in, .wr_lo_in(wr_lo_out),
      .wr_hi_in(wr_hi_out), .lo_in(res_lo_out), .hi_in(res_hi_out), .lo_out(rf_lo),
      .hi_out(rf_hi));
   // Verdict in one place, for the tests and the watchdog alike
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Software port: one-cycle strobes, read data only in the next cycle
   task automatic reg_put(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock_in);
      {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
      @(posedge clock_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic reg_chk(input logic [2:0] a, input logic [7:0] e);
      @(posedge clock_in);
      {reg_addr_in, reg_rd_in} <= {a, 1'b1};
      @(posedge clock_in);
      reg_rd_in <= 1'b0;
      #1;
      `ABX_CHK(reg_rdata_out, e)
   endtask
   // Operand bytes fill every op input; done is awaited 8 cycles at most
   task automatic op_run(input logic [5:0] oc, input logic [7:0] a, b, k, input int n);
      int cyc;
      @(posedge clock_in);
      {op_code_in, rd_val_in, rr_val_in, imm_in} <= {oc, a, b, k};
      {pair_in, z_ptr_in, offset_in, next_two_word_in} <= {b, a, b, a, b[3:0], a, k[7]};
      op_valid_in <= 1'b1;
      @(posedge clock_in);
      op_valid_in <= 1'b0;
      cyc = 1;
      #1;
      while (done_out !== 1'b1 && cyc < 8) begin
         @(posedge clock_in);
         cyc++;
         #1;
      end
      `ABX_CHK(cyc, n)
   endtask
   // Fields of v: preset status, rd, rr, constant, flags, result hi:lo
   task automatic alu(input logic [5:0] oc, input logic [55:0] v, input int n);
      reg_put(`ABX_REG_STATUS, v[55:48]);
      op_run(oc, v[47:40], v[39:32], v[31:24], n);
      `ABX_CHK(status_out, v[23:16])
      `ABX_CHK(wr_hi_out, n == 2)
      @(posedge clock_in);
      #1;
      `ABX_CHK(rf_lo, v[7:0])
      if (n == 2) `ABX_CHK(rf_hi, v[15:8])
   endtask
   // Flow ops start from pc 0x0100 and status 0x55; v is rd, rr, constant
   task automatic flow(input logic [5:0] oc, input logic [23:0] v, input int n,
      input logic [15:0] epc, input logic [7:0] est);
      reg_put(`ABX_REG_PC_LO, 8'h00);
      reg_put(`ABX_REG_PC_HI, 8'h01);
      reg_put(`ABX_REG_STATUS, 8'h55);
      op_run(oc, v[23:16], v[15:8], v[7:0], n);
      `ABX_CHK(pc_out, epc)
      `ABX_CHK(status_out, est)
   endtask
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   // Watchdog: the tests need under 1000 cycles
   initial begin
      #20000;
      miscompares++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      {nrst_in, op_valid_in, next_two_word_in, reg_wr_in, reg_rd_in, op_code_in} = '0;
      {rd_val_in, rr_val_in, imm_in, reg_wdata_in, pair_in, z_ptr_in, offset_in} = '0;
      reg_addr_in = 3'h0;
      ce_in = 1'b1;
      repeat (3) @(posedge clock_in);
      nrst_in <= 1'b1;
      // Reset values, a read-only offset and an unmapped one
      reg_chk(`ABX_REG_STATUS, 8'h00);
      reg_chk(`ABX_REG_PC_HI, 8'h00);
      reg_put(`ABX_REG_DEPTH, 8'h05);
      reg_chk(`ABX_REG_DEPTH, 8'h00);
      reg_put(3'h6, 8'hFF);
      reg_chk(3'h6, 8'h00);
      $display("test registers done");
      alu(`ABX_OP_SUM, 56'h008F7100230000, 1);
      alu(`ABX_OP_SUM_CARRY, 56'h117F00003C0080, 1);
      alu(`ABX_OP_DIFF_REGS, 56'h001020000500F0, 1);
      alu(`ABX_OP_DIFF_RB, 56'h0180000028007F, 1);
      alu(`ABX_OP_DIFF_IMM, 56'h00053305020000, 1);
      alu(`ABX_OP_DIFF_IB, 56'h010000FF230000, 1);
      alu(`ABX_OP_PAIR_PLUS, 56'h20FF7FC12C8000, 2);
      alu(`ABX_OP_PAIR_MINUS, 56'h0000003F15FFC1, 2);
      alu(`ABX_OP_CONJ_REGS, 56'h29F08C00250080, 1);
      alu(`ABX_OP_CONJ_IMM, 56'h000FFFF0020000, 1);
      alu(`ABX_OP_DISJ_REGS, 56'h08018000040081, 1);
      alu(`ABX_OP_DISJ_IMM, 56'h04000000020000, 1);
      alu(`ABX_OP_XOR_REGS, 56'h01AA55000500FF, 1);
      alu(`ABX_OP_SET_MASK, 56'h00100081040091, 1);
      alu(`ABX_OP_ONES_INV, 56'h280000002500FF, 1);
      alu(`ABX_OP_TWOS_INV, 56'h208000000D0080, 1);
      alu(`ABX_OP_TWOS_INV, 56'h000100002500FF, 1);
      alu(`ABX_OP_CLR_MASK, 56'h00FF000F0400F0, 1);
      alu(`ABX_OP_PLUS_ONE, 56'h217F00002D0080, 1);
      alu(`ABX_OP_MINUS_ONE, 56'h0480000008007F, 1);
      alu(`ABX_OP_ZERO_REG, 56'h0C5C5C00020000, 1);
      alu(`ABX_OP_ZS_CHECK, 56'h09808000050080, 1);
      alu(`ABX_OP_ONES_REG, 56'h6B1200006B00FF, 1);
      alu(`ABX_OP_PROD_U, 56'h3CFFFF003DFE01, 2);
      alu(`ABX_OP_PROD_S, 56'h02FF020001FFFE, 2);
      alu(`ABX_OP_PROD_M, 56'h0080020001FF00, 2);
      alu(`ABX_OP_FPROD_U, 56'h01808000008000, 2);
      alu(`ABX_OP_FPROD_S, 56'h00C0400001E000, 2);
      alu(`ABX_OP_FPROD_M, 56'h02FF810001FEFE, 2);
      $display("test alu done");
      flow(`ABX_OP_REL_GOTO, 24'hFE0F00, 2, 16'h00FF, 8'h55);
      flow(`ABX_OP_PTR_GOTO, 24'h341200, 2, 16'h1234, 8'h55);
      flow(`ABX_OP_REL_ENTER, 24'h100000, 3, 16'h0111, 8'h55);
      reg_chk(`ABX_REG_DEPTH, 8'h01);
      flow(`ABX_OP_SUB_EXIT, 24'h000000, 4, 16'h0101, 8'h55);
      reg_chk(`ABX_REG_DEPTH, 8'h00);
      flow(`ABX_OP_PTR_ENTER, 24'h000200, 3, 16'h0200, 8'h55);
      flow(`ABX_OP_IRQ_EXIT, 24'h000000, 4, 16'h0101, 8'hD5);
      flow(`ABX_OP_EQ_SKIP, 24'h333480, 1, 16'h0101, 8'h55);
      flow(`ABX_OP_EQ_SKIP, 24'h333300, 2, 16'h0102, 8'h55);
      flow(`ABX_OP_EQ_SKIP, 24'h333380, 3, 16'h0103, 8'h55);
      reg_chk(`ABX_REG_PC_LO, 8'h03);
      $display("test flow done");
      tally_and_finish();
   end
endmodule // abx_core_tb
